// ---- bench/ssd_disp_model.sv ----
// Purpose: model of the three digit display, turns segments back into glyphs
// Assumes: segments gfedcba, 1 = lit
// Notes:   an unknown pattern reads as 5'h1F
`timescale 1ns/1ps
`default_nettype none
module ssd_disp_model
	import ssd_pkg::*;
(
	// segments from the block
	input  wire logic [6:0] seg0,
	input  wire logic [6:0] seg1,
	input  wire logic [6:0] seg2,
	// decoded glyphs
	output logic      [4:0] gly0,
	output logic      [4:0] gly1,
	output logic      [4:0] gly2
);
	function automatic logic [4:0] decode(input logic [6:0] s);
		for (int i = 0; i < 17; i++) begin
			if (SEG_TAB[i] === s) begin
				return 5'(i);
			end
		end
		return 5'h1F;
	endfunction

	always_comb begin
		gly0 = decode(seg0);
		gly1 = decode(seg1);
		gly2 = decode(seg2);
	end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self checking bench of the servo status display
// Assumes: short hold and flicker counts (20 and 4 cycles)
// Notes:   status flags packed W A N C I S T M
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssd_pkg::*;
	typedef struct {logic [7:0] f; logic [7:0] code; logic [31:0] exp;} ssd_row_t;
	logic        sys_clk = 1'b0, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [7:0]  wbAdr = 8'h00, alarmCode = 8'h00, pointTable = 8'hFF, flags = 8'h00;
	logic [31:0] wbDatI = 32'h0, wbDatO, rd;
	logic [6:0]  s0, s1, s2;
	logic [2:0]  dpOut;
	logic [4:0]  g0, g1, g2;
	int          err_count = 0, checks = 0, hi, lo;

	servo_status_display #(.READY_HOLD_CYCLES(20), .FLICKER_CYCLES(4)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.commUp(flags[4]), .initDone(flags[3]), .servoOn(flags[2]), .alarmActive(flags[6]),
		.warningActive(flags[5]), .alarmCode(alarmCode), .cpuWdogErr(flags[7]), .testMode(flags[1]),
		.testMotorless(flags[0]), .pointTable(pointTable), .segDig0(s0), .segDig1(s1), .segDig2(s2),
		.dpOut(dpOut));
	ssd_disp_model disp (.seg0(s0), .seg1(s1), .seg2(s2), .gly0(g0), .gly1(g1), .gly2(g2));

	function automatic logic [31:0] ex(logic [4:0] a, logic [4:0] b, logic [4:0] c, logic [2:0] d);
		return {14'h0, a, b, c, d};
	endfunction

	ssd_row_t rows [8] = '{
		'{8'h00, 8'h00, ex(GLY_C, 5'h00, 5'h05, 3'h0)},
		'{8'h08, 8'h00, ex(GLY_B, 5'h00, 5'h05, 3'h0)},
		'{8'h18, 8'h00, ex(GLY_C, 5'h00, 5'h05, 3'h0)},
		'{8'h5C, 8'h16, ex(GLY_A, 5'h01, 5'h06, 3'h0)},
		'{8'hDC, 8'h16, ex(GLY_8, GLY_8, GLY_8, DP_ALL)},
		'{8'h1A, 8'h00, ex(GLY_B, GLY_0, GLY_0, DP_TRAIL)},
		'{8'h1B, 8'h00, ex(GLY_D, GLY_0, GLY_0, DP_TRAIL)},
		'{8'h42, 8'h16, ex(GLY_A, 5'h01, 5'h06, 3'h0)}};

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge sys_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic put(input logic [7:0] f, input logic [7:0] c, input int w);
		flags <= f;
		alarmCode <= c;
		repeat (w) @(posedge sys_clk);
	endtask

	function automatic logic [31:0] obs();
		return {14'h0, g0, g1, g2, dpOut};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		#50000;
		err_count++;
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		put(8'h00, 8'h00, 3);
		chk(obs(), ex(GLY_C, 5'h00, 5'h01, 3'h0));
		wb(1'b1, REG_CTRL, 32'h5);
		wb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h5);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		$display("register test done");
		foreach (rows[i]) begin
			put(rows[i].f, rows[i].code, 3);
			chk(obs(), rows[i].exp);
		end
		$display("indication table done");
		put(8'h1C, 8'h00, 3);
		chk(obs(), ex(GLY_D, 5'h00, 5'h05, 3'h0));
		repeat (19) @(posedge sys_clk);
		chk(obs(), ex(GLY_D, 5'h00, 5'h05, 3'h0));
		@(posedge sys_clk);
		chk(obs(), ex(5'h02, 5'h05, 5'h05, 3'h0));
		pointTable <= 8'h00;
		repeat (3) @(posedge sys_clk);
		chk(obs(), ex(5'h00, 5'h00, 5'h00, 3'h0));
		put(8'h5C, 8'h16, 3);
		put(8'h1C, 8'h00, 2);
		chk({27'h0, g0}, {27'h0, GLY_C});
		@(posedge sys_clk);
		chk({27'h0, g0}, {27'h0, GLY_D});
		$display("ready sequence done");
		foreach (rows[k]) begin
			put(8'h3C, (k == 0) ? 8'h21 : WARN_EXCL_CODE, 3);
			hi = 0;
			lo = 0;
			repeat (12) begin
				@(posedge sys_clk);
				if (dpOut[1] === 1'b1) hi++;
				else if (dpOut[1] === 1'b0) lo++;
			end
			chk(32'(hi > 0), 32'(k == 0));
			chk(32'(lo > 0), 32'h1);
			if (k == 1) break;
		end
		$display("flicker test done");
		wb(1'b1, REG_CTRL, 32'h40);
		put(8'h08, 8'h00, 3);
		chk(obs(), ex(GLY_B, 5'h06, 5'h04, 3'h0));
		wb(1'b0, REG_DISP, 32'h0);
		chk(rd, {17'h0, 5'h04, 5'h06, GLY_B});
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rd & 32'h0000_007F, {28'h0, ST_WAIT});
		put(8'h00, 8'h00, 1);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(obs(), ex(GLY_C, 5'h00, 5'h01, 3'h0));
		$display("reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- rtl/servo_status_display.sv ----
// Purpose: three digit seven segment status display of a servo drive
// Assumes: status inputs synchronous to sys_clk; Wishbone classic slave
// Notes:   digit 0 is the leftmost (letter) digit
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - b plus station until fieldbus link up
// - ready shows d plus station two seconds
// - initializing or servo off shows C plus station
// - after two seconds show executing point table
// - alarm or warning shows A plus code
// - watchdog error shows 888, all segments
// - warning with servo on flickers second dp, except code E6
// - station code 00 in test, else station
// - test mode b00. or motorless d00.
module servo_status_display
	import ssd_pkg::*;
#(
	parameter int unsigned READY_HOLD_CYCLES = 32'(READY_HOLD_CYC),
	parameter int unsigned FLICKER_CYCLES    = 32'(FLICKER_CYC)
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// drive status
	input  wire logic        commUp,
	input  wire logic        initDone,
	input  wire logic        servoOn,
	input  wire logic        alarmActive,
	input  wire logic        warningActive,
	input  wire logic [7:0]  alarmCode,
	input  wire logic        cpuWdogErr,
	input  wire logic        testMode,
	input  wire logic        testMotorless,
	input  wire logic [7:0]  pointTable,
	// display
	output logic      [6:0]  segDig0,
	output logic      [6:0]  segDig1,
	output logic      [6:0]  segDig2,
	output logic      [2:0]  dpOut
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [11:0] toBcd(input logic [7:0] bin);
		logic [11:0] acc;
		acc = 12'h000;
		for (int i = 7; i >= 0; i--) begin
			if (acc[3:0] > 4'h4) begin
				acc[3:0] = acc[3:0] + 4'h3;
			end
			if (acc[7:4] > 4'h4) begin
				acc[7:4] = acc[7:4] + 4'h3;
			end
			acc = {acc[10:0], bin[i]};
		end
		return acc;
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ssd_state_t  stateR,   stateNxt;
	logic [31:0] holdCntR, holdCntNxt;
	logic [31:0] flkCntR,  flkCntNxt;
	logic        flkR,     flkNxt;
	logic [6:0]  stnR,     stnNxt;
	logic        ackR,     ackNxt;
	logic [31:0] rdatR,    rdatNxt;
	logic [4:0]  gly0R, gly1R, gly2R;
	logic [4:0]  gly0Nxt, gly1Nxt, gly2Nxt;
	logic [2:0]  dpR,      dpNxt;
	logic [6:0]  seg0Nxt, seg1Nxt, seg2Nxt;
	logic [6:0]  seg0R, seg1R, seg2R;
	logic [11:0] stnBcd;
	logic [11:0] ptBcd;
	logic        showFlk;

	// ------------------------------------------------------------------
	// display sequence
	// ------------------------------------------------------------------
	always_comb begin
		stateNxt   = stateR;
		holdCntNxt = 32'h0000_0000;
		if (!initDone || alarmActive) begin
			stateNxt = ST_NOTRDY;
		end else if (!commUp) begin
			stateNxt = ST_WAIT;
		end else if (!servoOn) begin
			stateNxt = ST_NOTRDY;
		end else begin
			unique case (stateR)
				ST_READY: begin
					if (holdCntR >= READY_HOLD_CYCLES - 32'd1) begin
						stateNxt = ST_RUN;
					end else begin
						holdCntNxt = holdCntR + 32'd1;
					end
				end
				ST_RUN: begin
					stateNxt = ST_RUN;
				end
				default: begin
					stateNxt = ST_READY;
				end
			endcase
		end
	end

	always_comb begin
		if (flkCntR >= FLICKER_CYCLES - 32'd1) begin
			flkCntNxt = 32'h0000_0000;
			flkNxt    = ~flkR;
		end else begin
			flkCntNxt = flkCntR + 32'd1;
			flkNxt    = flkR;
		end
	end

	// ------------------------------------------------------------------
	// glyph selection
	// ------------------------------------------------------------------
	assign stnBcd  = toBcd({1'b0, testMode ? STN_TEST : stnR});
	assign ptBcd   = toBcd(pointTable);
	assign showFlk = warningActive && !alarmActive && servoOn && (alarmCode != WARN_EXCL_CODE);

	always_comb begin
		gly0Nxt = GLY_C;
		gly1Nxt = {1'b0, stnBcd[7:4]};
		gly2Nxt = {1'b0, stnBcd[3:0]};
		dpNxt   = 3'h0;
		if (cpuWdogErr) begin
			gly0Nxt = GLY_8;
			gly1Nxt = GLY_8;
			gly2Nxt = GLY_8;
			dpNxt   = DP_ALL;
		end else if (alarmActive || warningActive) begin
			gly0Nxt = GLY_A;
			gly1Nxt = {1'b0, alarmCode[7:4]};
			gly2Nxt = {1'b0, alarmCode[3:0]};
			dpNxt   = (showFlk && flkR) ? DP_SECOND : 3'h0;
		end else if (testMode) begin
			gly0Nxt = testMotorless ? GLY_D : GLY_B;
			dpNxt   = DP_TRAIL;
		end else begin
			unique case (stateR)
				ST_WAIT:  gly0Nxt = GLY_B;
				ST_READY: gly0Nxt = GLY_D;
				ST_RUN: begin
					gly0Nxt = {1'b0, ptBcd[11:8]};
					gly1Nxt = {1'b0, ptBcd[7:4]};
					gly2Nxt = {1'b0, ptBcd[3:0]};
				end
				default:  gly0Nxt = GLY_C;
			endcase
		end
	end

	ssd_seg_enc uEnc0 (.glyph(gly0Nxt), .seg(seg0Nxt));
	ssd_seg_enc uEnc1 (.glyph(gly1Nxt), .seg(seg1Nxt));
	ssd_seg_enc uEnc2 (.glyph(gly2Nxt), .seg(seg2Nxt));

	// ------------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------------
	always_comb begin
		ackNxt  = wb_cyc_i && wb_stb_i && !ackR;
		stnNxt  = stnR;
		rdatNxt = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && ackR && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
			stnNxt = wb_dat_i[CTRL_STN_MSB:0];
		end
		unique case (wb_adr_i)
			REG_CTRL:   rdatNxt = {25'h0, stnR};
			REG_STATUS: rdatNxt = {24'h0, flkR, dpR, stateR};
			REG_DISP:   rdatNxt = {17'h0, gly2R, gly1R, gly0R};
			default:    rdatNxt = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stateR   <= ST_NOTRDY;
			holdCntR <= 32'h0000_0000;
			flkCntR  <= 32'h0000_0000;
			flkR     <= 1'b0;
			stnR     <= CTRL_STN_RESET;
			ackR     <= 1'b0;
			rdatR    <= 32'h0000_0000;
			gly0R    <= GLY_BLANK;
			gly1R    <= GLY_BLANK;
			gly2R    <= GLY_BLANK;
			dpR      <= 3'h0;
			seg0R    <= 7'h00;
			seg1R    <= 7'h00;
			seg2R    <= 7'h00;
		end else begin
			stateR   <= stateNxt;
			holdCntR <= holdCntNxt;
			flkCntR  <= flkCntNxt;
			flkR     <= flkNxt;
			stnR     <= stnNxt;
			ackR     <= ackNxt;
			rdatR    <= rdatNxt;
			gly0R    <= gly0Nxt;
			gly1R    <= gly1Nxt;
			gly2R    <= gly2Nxt;
			dpR      <= dpNxt;
			seg0R    <= seg0Nxt;
			seg1R    <= seg1Nxt;
			seg2R    <= seg2Nxt;
		end
	end

	assign wb_ack_o = ackR;
	assign wb_dat_o = rdatR;
	assign segDig0  = seg0R;
	assign segDig1  = seg1R;
	assign segDig2  = seg2R;
	assign dpOut    = dpR;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_wait_letter_b: assert property (@(posedge sys_clk) disable iff (!nrst)
		initDone && !alarmActive && !commUp
		##1 !cpuWdogErr && !alarmActive && !warningActive && !testMode && initDone && !commUp
		|=> gly0R == GLY_B && gly1R == {1'b0, $past(stnBcd[7:4])})
		else $error("waiting link not shown as b");

	a_ready_hold_d: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(stateR == ST_RUN) |-> $past(stateR) == ST_READY && $past(holdCntR) == READY_HOLD_CYCLES - 32'd1)
		else $error("run entered before ready hold elapsed");

	a_notready_c: assert property (@(posedge sys_clk) disable iff (!nrst)
		!cpuWdogErr && !warningActive && !testMode && !alarmActive && stateR == ST_NOTRDY
		|=> gly0R == GLY_C)
		else $error("not ready not shown as C");

	a_run_table_no: assert property (@(posedge sys_clk) disable iff (!nrst)
		stateR == ST_RUN && !cpuWdogErr && !alarmActive && !warningActive && !testMode
		|=> {gly0R[3:0], gly1R[3:0], gly2R[3:0]} == $past(ptBcd))
		else $error("point table number not shown");

	a_alarm_code: assert property (@(posedge sys_clk) disable iff (!nrst)
		!cpuWdogErr && alarmActive |=> gly0R == GLY_A && gly2R == {1'b0, $past(alarmCode[3:0])})
		else $error("alarm code not shown");

	a_wdog_eights: assert property (@(posedge sys_clk) disable iff (!nrst)
		cpuWdogErr |=> segDig0 == 7'h7F && segDig1 == 7'h7F && segDig2 == 7'h7F && dpOut == DP_ALL)
		else $error("watchdog error not shown as 888");

	a_flicker_dp: assert property (@(posedge sys_clk) disable iff (!nrst)
		!cpuWdogErr && !alarmActive && warningActive && alarmCode == WARN_EXCL_CODE |=> dpOut == 3'h0)
		else $error("excluded warning lit decimal point");

	a_test_station: assert property (@(posedge sys_clk) disable iff (!nrst)
		!cpuWdogErr && !alarmActive && !warningActive && testMode
		|=> gly1R == GLY_0 && gly2R == GLY_0 && dpOut == DP_TRAIL)
		else $error("test mode indication wrong");

	a_reset_notready: assert property (@(posedge sys_clk) disable iff (!nrst)
		!initDone |=> stateR == ST_NOTRDY)
		else $error("left not ready before init done");

endmodule
`default_nettype wire

// ---- rtl/ssd_pkg.sv ----
// Purpose: shared constants for the servo status display
// Assumes: 200 MHz system clock
// Notes:   glyph codes 0x00..0x0F are hex digits, 0x10 is blank
package ssd_pkg;

	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam longint unsigned CLK_HZ          = 64'd200_000_000;
	localparam longint unsigned READY_HOLD_S    = 64'd2;
	localparam longint unsigned READY_HOLD_CYC  = READY_HOLD_S * CLK_HZ;
	localparam longint unsigned FLICKER_MS      = 64'd250;
	localparam longint unsigned FLICKER_CYC     = (FLICKER_MS * CLK_HZ) / 64'd1000;

	// --------------------------------------------------------------
	// register map (byte addresses) and fields
	// --------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_DISP        = 8'h08;
	localparam int          CTRL_STN_MSB    = 6;
	localparam logic [6:0]  CTRL_STN_RESET  = 7'h01;
	localparam logic [6:0]  STN_TEST        = 7'h00;
	localparam logic [7:0]  WARN_EXCL_CODE  = 8'hE6;

	// --------------------------------------------------------------
	// glyphs and segment table (gfedcba)
	// --------------------------------------------------------------
	localparam logic [4:0]  GLY_A           = 5'h0A;
	localparam logic [4:0]  GLY_B           = 5'h0B;
	localparam logic [4:0]  GLY_C           = 5'h0C;
	localparam logic [4:0]  GLY_D           = 5'h0D;
	localparam logic [4:0]  GLY_8           = 5'h08;
	localparam logic [4:0]  GLY_0           = 5'h00;
	localparam logic [4:0]  GLY_BLANK       = 5'h10;
	localparam logic [6:0]  SEG_TAB [0:16]  = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
	                                            7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71,
	                                            7'h00};
	localparam logic [2:0]  DP_ALL          = 3'h7;
	localparam logic [2:0]  DP_SECOND       = 3'h2;
	localparam logic [2:0]  DP_TRAIL        = 3'h4;

	// --------------------------------------------------------------
	// display sequence states
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_NOTRDY = 4'h1,
		ST_WAIT   = 4'h2,
		ST_READY  = 4'h4,
		ST_RUN    = 4'h8
	} ssd_state_t;

endpackage

// ---- rtl/ssd_seg_enc.sv ----
// Purpose: glyph code to seven segment pattern
// Assumes: codes above blank show nothing
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ssd_seg_enc
	import ssd_pkg::*;
(
	// glyph in
	input  wire logic [4:0] glyph,
	// segments out, gfedcba
	output logic      [6:0] seg
);

	always_comb begin
		if (glyph <= GLY_BLANK) begin
			seg = SEG_TAB[glyph];
		end else begin
			seg = SEG_TAB[GLY_BLANK];
		end
	end

endmodule
`default_nettype wire
